// ---- tap_map.svh ----
// constants of the memory test access port: lengths, codes, id fields, cell positions
`ifndef TAP_MAP_SVH
`define TAP_MAP_SVH

// ==========================================
// register lengths
`define IR_LEN 8
`define BSR_LEN 113
`define ID_LEN 32

// ==========================================
// instruction codes
`define INS_EXTERNAL_TEST 8'h00
`define INS_IDENTIFY 8'h21
`define INS_SAMPLE_PRELOAD 8'h05
`define INS_CLAMP 8'h07
`define INS_HIGH_Z 8'h03
`define INS_BYPASS 8'hff
// value loaded into the instruction shifter in capture-ir
`define IR_CAPTURE_VAL 8'h01

// ==========================================
// identification register fields
`define ID_PRESENT_BIT 0
`define ID_MFR_LSB 1
`define ID_MFR_W 11
`define ID_DEV_LSB 12
`define ID_DEV_W 16
`define ID_WIDTH_LSB 28
`define ID_REV_LSB 30
`define WIDTH_X9 2'h0
`define WIDTH_X18 2'h1
`define WIDTH_X36 2'h2

// ==========================================
// chain cell numbers, cell n sits at chain index n-1
`define CELL_WDCLK 1
`define CELL_WDCLK_N 2
`define CELL_CHIP_SEL 3
`define CELL_REFRESH 4
`define CELL_WRITE_EN 5
`define CELL_SYSCLK_N 57
`define CELL_SYSCLK_P 58

`endif

// ---- tap_pkg.sv ----
// types shared by the memory test access port
package tap_pkg;

	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR, ST_PAUSE_DR,
		ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SHIFT_IR, ST_EXIT1_IR,
		ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
	} tap_state_e;

	typedef enum logic [1:0] {
		DR_BYPASS, DR_IDENT, DR_BOUNDARY
	} dr_sel_e;

endpackage

// ---- pin_sync.sv ----
// three-stage synchroniser with agreement filter for pins from the test clock side
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 3
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] level
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a change is taken only once stages two and three agree
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge ref_clk) begin
				if (!nrst) begin
					level[i] <= 1'b0;
				end else if (s2_q[i] == s3_q[i]) begin
					level[i] <= s3_q[i];
				end
			end
		end
	endgenerate
endmodule

// ---- tap_fsm.sv ----
// sixteen-state test port controller, advanced on each test clock rise
`timescale 1ns/1ps
module tap_fsm (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic adv,
	input wire logic mode_sel,
	output tap_pkg::tap_state_e state
);
	import tap_pkg::*;

	tap_state_e state_d;

	always_comb begin
		state_d = state;
		unique case (state)
			ST_RESET: state_d = mode_sel ? ST_RESET : ST_IDLE;
			ST_IDLE: state_d = mode_sel ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: state_d = mode_sel ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: state_d = mode_sel ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR: state_d = mode_sel ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR: state_d = mode_sel ? ST_UPD_DR : ST_PAUSE_DR;
			ST_PAUSE_DR: state_d = mode_sel ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR: state_d = mode_sel ? ST_UPD_DR : ST_SHIFT_DR;
			ST_UPD_DR: state_d = mode_sel ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: state_d = mode_sel ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR: state_d = mode_sel ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR: state_d = mode_sel ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR: state_d = mode_sel ? ST_UPD_IR : ST_PAUSE_IR;
			ST_PAUSE_IR: state_d = mode_sel ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR: state_d = mode_sel ? ST_UPD_IR : ST_SHIFT_IR;
			ST_UPD_IR: state_d = mode_sel ? ST_SEL_DR : ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			state <= ST_RESET;
		end else if (adv) begin
			state <= state_d;
		end
	end
endmodule

// ---- mem_tap.sv ----
// test access port of the memory: instruction decode, data registers, output forcing
`timescale 1ns/1ps
`include "tap_map.svh"
module mem_tap #(
	parameter logic [1:0] DIE_REV = 2'h0,
	parameter logic [1:0] WIDTH_CODE = `WIDTH_X36,
	// arbitrary value
	parameter logic [`ID_DEV_W-1:0] DEVICE_CODE = 16'h0000,
	// arbitrary value
	parameter logic [`ID_MFR_W-1:0] MFR_CODE = 11'h000,
	parameter logic [`BSR_LEN-1:0] UNUSED_CELLS = '0
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic [`BSR_LEN-1:0] ring_in,
	output logic tdo,
	output logic tdo_oe,
	output logic [`BSR_LEN-1:0] ring_drive,
	output logic drive_from_chain,
	output logic outputs_hiz,
	output logic [`IR_LEN-1:0] active_ins,
	output tap_pkg::tap_state_e tap_state
);
	import tap_pkg::*;

	// ==========================================
	// instruction decode
	function automatic dr_sel_e dr_of(input logic [`IR_LEN-1:0] ins);
		unique case (ins)
			`INS_EXTERNAL_TEST: dr_of = DR_BOUNDARY;
			`INS_SAMPLE_PRELOAD: dr_of = DR_BOUNDARY;
			`INS_IDENTIFY: dr_of = DR_IDENT;
			// reserved codes fall to bypass
			default: dr_of = DR_BYPASS;
		endcase
	endfunction

	function automatic logic drives_chain(input logic [`IR_LEN-1:0] ins);
		drives_chain = (ins == `INS_EXTERNAL_TEST) || (ins == `INS_CLAMP);
	endfunction

	// ==========================================
	// pin sampling and test clock edges
	logic [2:0] pins_f;
	logic tck_prev_q;
	logic tck_rise;
	logic tck_fall;
	logic tms_f;
	logic tdi_f;

	pin_sync #(.W(3)) u_sync (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.pin({tdi, tms, tck}),
		.level(pins_f)
	);

	assign tms_f = pins_f[1];
	assign tdi_f = pins_f[2];
	assign tck_rise = pins_f[0] & ~tck_prev_q;
	assign tck_fall = ~pins_f[0] & tck_prev_q;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			tck_prev_q <= 1'b0;
		end else begin
			tck_prev_q <= pins_f[0];
		end
	end

	tap_state_e state;

	tap_fsm u_fsm (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.adv(tck_rise),
		.mode_sel(tms_f),
		.state(state)
	);

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			tap_state <= ST_RESET;
		end else begin
			tap_state <= state;
		end
	end

	// ==========================================
	// instruction register
	logic [`IR_LEN-1:0] ir_shift_q;
	localparam logic [`IR_LEN-1:0] IR_CAP = `IR_CAPTURE_VAL;

	// one cell per instruction bit: tdi enters at the top, bit 0 faces tdo
	genvar k;
	generate
		for (k = 0; k < `IR_LEN; k++) begin : g_ir
			logic ir_next;

			if (k == `IR_LEN - 1) begin : g_tail
				assign ir_next = tdi_f;
			end else begin : g_link
				assign ir_next = ir_shift_q[k + 1];
			end

			always_ff @(posedge ref_clk) begin
				if (!nrst) begin
					ir_shift_q[k] <= IR_CAP[k];
				end else if (tck_rise && state == ST_CAP_IR) begin
					ir_shift_q[k] <= IR_CAP[k];
				end else if (tck_rise && state == ST_SHIFT_IR) begin
					ir_shift_q[k] <= ir_next;
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			active_ins <= `INS_IDENTIFY;
		end else if (state == ST_RESET) begin
			active_ins <= `INS_IDENTIFY;
		end else if (tck_rise && state == ST_UPD_IR) begin
			active_ins <= ir_shift_q;
		end
	end

	// ==========================================
	// data registers
	logic bypass_q;
	logic [`ID_LEN-1:0] id_shift_q;
	logic [`BSR_LEN-1:0] bsr_q;
	logic [`ID_LEN-1:0] id_value;
	logic [`BSR_LEN-1:0] ring_capture;
	dr_sel_e dr_sel;

	assign dr_sel = dr_of(active_ins);

	always_comb begin
		id_value = '0;
		id_value[`ID_PRESENT_BIT] = 1'b1;
		id_value[`ID_MFR_LSB +: `ID_MFR_W] = MFR_CODE;
		id_value[`ID_DEV_LSB +: `ID_DEV_W] = DEVICE_CODE;
		id_value[`ID_WIDTH_LSB +: 2] = WIDTH_CODE;
		id_value[`ID_REV_LSB +: 2] = DIE_REV;
	end

	// unused cells capture zero but remain in the chain
	assign ring_capture = ring_in & ~UNUSED_CELLS;

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			bypass_q <= 1'b0;
		end else if (tck_rise && dr_sel == DR_BYPASS) begin
			if (state == ST_CAP_DR) begin
				bypass_q <= 1'b0;
			end else if (state == ST_SHIFT_DR) begin
				bypass_q <= tdi_f;
			end
		end
	end

	// identification cells: the fixed code is captured whole, bit 0 faces tdo
	genvar j;
	generate
		for (j = 0; j < `ID_LEN; j++) begin : g_id
			logic id_next;

			if (j == `ID_LEN - 1) begin : g_tail
				assign id_next = tdi_f;
			end else begin : g_link
				assign id_next = id_shift_q[j + 1];
			end

			always_ff @(posedge ref_clk) begin
				if (!nrst) begin
					id_shift_q[j] <= 1'b0;
				end else if (tck_rise && dr_sel == DR_IDENT && state == ST_CAP_DR) begin
					id_shift_q[j] <= id_value[j];
				end else if (tck_rise && dr_sel == DR_IDENT && state == ST_SHIFT_DR) begin
					id_shift_q[j] <= id_next;
				end
			end
		end
	endgenerate

	// boundary chain: cell n sits at index n-1, so cell 1 (write data clock) leaves first
	logic bsr_capture;
	logic bsr_shift;
	logic bsr_update;

	assign bsr_capture = tck_rise && dr_sel == DR_BOUNDARY && state == ST_CAP_DR;
	assign bsr_shift = tck_rise && dr_sel == DR_BOUNDARY && state == ST_SHIFT_DR;
	assign bsr_update = tck_rise && dr_sel == DR_BOUNDARY && state == ST_UPD_DR;

	genvar c;
	generate
		for (c = 0; c < `BSR_LEN; c++) begin : g_cell
			logic cell_next;

			if (c == `BSR_LEN - 1) begin : g_tail
				assign cell_next = tdi_f;
			end else begin : g_link
				assign cell_next = bsr_q[c + 1];
			end

			always_ff @(posedge ref_clk) begin
				if (!nrst) begin
					bsr_q[c] <= 1'b0;
				end else if (bsr_capture) begin
					bsr_q[c] <= ring_capture[c];
				end else if (bsr_shift) begin
					bsr_q[c] <= cell_next;
				end
			end

			// update latch; the pins use it only while drive_from_chain is high
			always_ff @(posedge ref_clk) begin
				if (!nrst) begin
					ring_drive[c] <= 1'b0;
				end else if (bsr_update) begin
					ring_drive[c] <= bsr_q[c];
				end
			end
		end
	endgenerate

	// ==========================================
	// output forcing
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			drive_from_chain <= 1'b0;
		end else begin
			drive_from_chain <= drives_chain(active_ins);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			outputs_hiz <= 1'b0;
		end else begin
			outputs_hiz <= (active_ins == `INS_HIGH_Z);
		end
	end

	// ==========================================
	// serial output, changes on the test clock fall
	logic tdo_d;
	logic shifting;

	always_comb begin
		tdo_d = 1'b0;
		if (state == ST_SHIFT_IR) begin
			tdo_d = ir_shift_q[0];
		end else begin
			unique case (dr_sel)
				DR_BYPASS: tdo_d = bypass_q;
				DR_IDENT: tdo_d = id_shift_q[0];
				DR_BOUNDARY: tdo_d = bsr_q[0];
			endcase
		end
	end

	assign shifting = (state == ST_SHIFT_IR) || (state == ST_SHIFT_DR);

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			tdo <= 1'b0;
		end else if (tck_fall) begin
			tdo <= shifting ? tdo_d : 1'b0;
		end
	end

	// enable of the serial output pad, high only across the shift window
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			tdo_oe <= 1'b0;
		end else if (tck_fall) begin
			tdo_oe <= shifting;
		end
	end
endmodule

// ---- mem_tap_sva.sv ----
// assertion checker for the memory test access port
`timescale 1ns/1ps
`include "tap_map.svh"
module mem_tap_chk (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic tdo,
	input wire logic tdo_oe,
	input wire logic [`BSR_LEN-1:0] ring_drive,
	input wire logic drive_from_chain,
	input wire logic outputs_hiz,
	input wire logic [`IR_LEN-1:0] active_ins,
	input wire tap_pkg::tap_state_e tap_state
);
	import tap_pkg::*;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!nrst);
	AST_RESET_LOAD: assert property (disable iff (1'b0)
		!nrst |=> active_ins == `INS_IDENTIFY && tap_state == ST_RESET)
		else $error("no identify after reset");
	AST_TLR_LOAD: assert property (tap_state == ST_RESET |-> ##[0:2] active_ins == 8'h21)
		else $error("no identify in test-logic-reset");
	AST_HIZ_SET: assert property (active_ins == `INS_HIGH_Z |=> outputs_hiz)
		else $error("outputs not forced off");
	AST_HIZ_CAUSE: assert property (outputs_hiz |-> $past(active_ins) == `INS_HIGH_Z)
		else $error("outputs forced off wrongly");
	AST_DRIVE_SET: assert property (active_ins inside {8'h00, 8'h07} |=> drive_from_chain)
		else $error("outputs not driven from chain");
	AST_DRIVE_CAUSE: assert property (drive_from_chain |-> $past(active_ins) inside {8'h00, 8'h07})
		else $error("chain drive wrongly set");
	AST_OE_SHIFT: assert property (tdo_oe |-> tap_state inside
		{ST_SHIFT_IR, ST_EXIT1_IR, ST_SHIFT_DR, ST_EXIT1_DR})
		else $error("serial output enabled outside shift");
	AST_TDO_IDLE: assert property (!tdo_oe |-> !tdo)
		else $error("serial output not low when off");
	AST_RING_CAUSE: assert property (!$stable(ring_drive) |-> active_ins inside {8'h00, 8'h05})
		else $error("chain latch changed wrongly");
endmodule
bind mem_tap mem_tap_chk mem_tap_chk_i (.ref_clk(ref_clk), .nrst(nrst), .tdo(tdo),
	.tdo_oe(tdo_oe), .ring_drive(ring_drive), .drive_from_chain(drive_from_chain),
	.outputs_hiz(outputs_hiz), .active_ins(active_ins), .tap_state(tap_state));

// ---- tap_ctl_model.sv ----
// board test controller model driving the test clock, mode and data pins
`timescale 1ns/1ps
module tap_ctl_model (
	input wire logic ref_clk,
	output logic tck,
	output logic tms,
	output logic tdi,
	input wire logic tdo
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// one test clock period of 800 ns: fall with new mode and data, rise, read tdo
	task automatic step(input logic m, input logic d, output logic q);
		@(posedge ref_clk);
		tck <= 1'b0;
		tms <= m;
		tdi <= d;
		repeat (4) @(posedge ref_clk);
		tck <= 1'b1;
		repeat (3) @(posedge ref_clk);
		q = tdo;
	endtask
endmodule

// ---- test_mem_tap.sv ----
// testbench of the memory test access port
`timescale 1ns/1ps
`include "tap_map.svh"
module test_mem_tap;
	import tap_pkg::*;
	localparam logic [`BSR_LEN-1:0] PAT = 113'h1_2345_6789_abcd_ef01_2345_6789_abcd;
	// cells 12, 13, 16 and 17 carry no pin at x18
	localparam logic [`BSR_LEN-1:0] UNUSED_X18 = 113'h1_9800;
	logic ref_clk = 1'b0;
	logic nrst = 1'b0;
	logic [`BSR_LEN-1:0] ring_in = '0;
	logic [`BSR_LEN-1:0] rd;
	wire tck, tms, tdi, tdo, tdo_oe, drive_from_chain, outputs_hiz;
	wire [`BSR_LEN-1:0] ring_drive;
	wire [`IR_LEN-1:0] active_ins;
	tap_state_e tap_state;
	int err_count = 0;
	int check_count = 0;
	logic [7:0] codes [6] = '{8'h00, 8'h21, 8'h05, 8'h07, 8'h03, 8'hff};
	always #50 ref_clk = ~ref_clk;
	tap_ctl_model tap_ctl_model_i (.ref_clk(ref_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
	// identity fields are arbitrary values
	mem_tap #(.DIE_REV(2'h1), .WIDTH_CODE(`WIDTH_X18), .DEVICE_CODE(16'h1234),
		.MFR_CODE(11'h2a5), .UNUSED_CELLS(UNUSED_X18)) mem_tap_i (.ref_clk(ref_clk),
		.nrst(nrst), .tck(tck), .tms(tms),
		.tdi(tdi), .ring_in(ring_in), .tdo(tdo), .tdo_oe(tdo_oe), .ring_drive(ring_drive),
		.drive_from_chain(drive_from_chain), .outputs_hiz(outputs_hiz),
		.active_ins(active_ins), .tap_state(tap_state));
	task automatic chk(input logic [`BSR_LEN-1:0] seen, input logic [`BSR_LEN-1:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic walk(input logic [7:0] m, input int n);
		logic b;
		for (int i = 0; i < n; i++) tap_ctl_model_i.step(m[i], 1'b0, b);
	endtask
	// shift n bits lsb first through ir or dr from idle, then back to idle
	task automatic scan(input logic ir, input int n, input logic [`BSR_LEN-1:0] din);
		logic b;
		rd = '0;
		walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
		for (int i = 0; i < n; i++) begin
			tap_ctl_model_i.step(i == n - 1, din[i], b);
			rd[i] = b;
			if (i == 0) chk(tdo_oe, 1'b1);
		end
		walk(8'h01, 2);
		repeat (8) @(posedge ref_clk);
	endtask
	task automatic summarize;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#1000000;
		err_count++;
		summarize();
	end
	// ==========================================
	// tests
	initial begin
		repeat (16) @(posedge ref_clk);
		nrst <= 1'b1;
		chk(active_ins, `INS_IDENTIFY);
		walk(8'h00, 1);
		scan(1'b0, 32, '0);
		chk(rd[31:0], {2'h1, `WIDTH_X18, 16'h1234, 11'h2a5, 1'b1});
		chk(tdo_oe, 1'b0);
		$display("identify test done");
		foreach (codes[i]) begin
			scan(1'b1, 8, codes[i]);
			chk(rd[7:0], `IR_CAPTURE_VAL);
			chk(active_ins, codes[i]);
			chk(outputs_hiz, codes[i] == `INS_HIGH_Z);
			chk(drive_from_chain, codes[i] == 8'h00 || codes[i] == 8'h07);
			scan(1'b0, 9, 113'h15a);
			if (codes[i] inside {8'h07, 8'h03, 8'hff}) chk(rd[8:0], 9'h0b4);
			if (codes[i] == `INS_IDENTIFY) chk(rd[8:0], {8'ha5, 1'b1});
		end
		$display("instruction test done");
		scan(1'b1, 8, `INS_SAMPLE_PRELOAD);
		ring_in <= PAT;
		scan(1'b0, `BSR_LEN, ~PAT);
		chk(rd, PAT & ~UNUSED_X18);
		chk(ring_drive, ~PAT);
		$display("chain test done");
		walk(8'h1f, 5);
		repeat (8) @(posedge ref_clk);
		chk(active_ins, `INS_IDENTIFY);
		chk(tap_state, ST_RESET);
		$display("reset state test done");
		summarize();
	end
endmodule
